// [rtl/can_msg_status_pkg.sv]
// Package: register map, field positions and event carriers for the message center status block
package can_msg_status_pkg;
   localparam int NUM_CENTERS = 15;
   // Printed offsets are word indexes; byte address is four times the index
   localparam logic [7:0] TX_ACK_FLAGS_IDX   = 8'h09;
   localparam logic [7:0] MSG_CENTER_ONE_IDX = 8'h11;
   localparam logic [7:0] CTRL_CFG_IDX       = 8'h20;
   localparam logic [11:0] TX_ACK_FLAGS_ADDR   = {2'h0, TX_ACK_FLAGS_IDX, 2'h0};
   localparam logic [11:0] MSG_CENTER_ONE_ADDR = {2'h0, MSG_CENTER_ONE_IDX, 2'h0};
   localparam logic [11:0] CTRL_CFG_ADDR       = {2'h0, CTRL_CFG_IDX, 2'h0};
   // Control register field positions
   localparam int SLOT_READY_BIT   = 7;
   localparam int TX_IRQ_EN_BIT    = 6;
   localparam int RX_IRQ_EN_BIT    = 5;
   localparam int SLOT_IRQ_REQ_BIT = 4;
   localparam int REMOTE_PEND_BIT  = 3;
   localparam int HOST_TX_REQ_BIT  = 2;
   localparam int HOLD_OVR_BIT     = 1;
   localparam int DATA_FRESH_BIT   = 0;
   // Configuration register fields
   localparam int SOFT_RESET_BIT    = 0;
   localparam int GLOBAL_IRQ_EN_BIT = 1;
   localparam int MODULE_MASK_BIT   = 2;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [14:0] ACK_RESET      = 15'h0000;
   localparam logic [2:0]  CFG_RESET      = 3'h0;

   // Events reported by the protocol engine, one bit per center
   typedef struct packed {
      logic [NUM_CENTERS-1:0] txDone;
      logic [NUM_CENTERS-1:0] rxStore;
      logic [NUM_CENTERS-1:0] remoteReq;
   } engine_evt_t;

   // Per-center permissions back to the protocol engine
   typedef struct packed {
      logic [NUM_CENTERS-1:0] slotEnabled;
      logic [NUM_CENTERS-1:0] txAllowed;
      logic [NUM_CENTERS-1:0] sendData;
      logic [NUM_CENTERS-1:0] sendRemote;
      logic [NUM_CENTERS-1:0] rxAllowed;
   } engine_ctl_t;
endpackage

// [rtl/can_message_center_status.sv]
// Message center control/status registers and transmit acknowledge flags behind APB
`timescale 1ns/1ps
module can_message_center_status #(
   parameter int NUM_CENTERS = can_msg_status_pkg::NUM_CENTERS
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // Protocol engine side
   input  wire can_msg_status_pkg::engine_evt_t engineEvt,
   input  wire logic [NUM_CENTERS-1:0]  txDirection,
   output can_msg_status_pkg::engine_ctl_t     engineCtl,
   // Interrupt request and soft reset status toward the processor
   output logic                         canIrq,
   output logic                         softResetActive
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        access;
   logic        wrStrobe;
   logic        rdStrobe;
   logic [9:0]  wordIdx;
   logic        hitAck;
   logic        hitCfg;
   logic [NUM_CENTERS-1:0] hitCenter;

   // Two-cycle access phase; pready rises in the second cycle
   assign access   = psel && penable && !pready;
   assign wrStrobe = access && pwrite;
   assign rdStrobe = access && !pwrite;
   assign wordIdx  = paddr[11:2];
   assign hitAck   = (paddr == can_msg_status_pkg::TX_ACK_FLAGS_ADDR);
   assign hitCfg   = (paddr == can_msg_status_pkg::CTRL_CFG_ADDR);

   genvar g;
   generate
      for (g = 0; g < NUM_CENTERS; g++) begin : gDecode
         // Centers sit at consecutive word indexes
         assign hitCenter[g] = (paddr[1:0] == 2'h0) &&
                               (wordIdx == 10'({2'h0, can_msg_status_pkg::MSG_CENTER_ONE_IDX} + g));
      end
   endgenerate

   // ----------------------------------------------------------------
   // Configuration: soft reset, global enable, module mask
   // ----------------------------------------------------------------
   logic [2:0] cfg_reg;
   logic       softRst;
   logic       anyRst;

   assign softRst = cfg_reg[can_msg_status_pkg::SOFT_RESET_BIT];
   assign anyRst  = rst || softRst;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_reg <= can_msg_status_pkg::CFG_RESET;
      end else if (wrStrobe && hitCfg) begin
         cfg_reg <= pwdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Transmit acknowledge flags
   // ----------------------------------------------------------------
   logic [NUM_CENTERS-1:0] ackFlags_reg;
   logic [NUM_CENTERS-1:0] ackFlags_next;
   logic [NUM_CENTERS-1:0] txOk;

   always_comb begin
      ackFlags_next = ackFlags_reg;
      if (rdStrobe && hitAck) begin
         ackFlags_next = '0;
      end
      ackFlags_next = ackFlags_next | txOk;
   end

   // Writes never reach these flags; the 15 flags fill bits 14:0, so bit 15 reads zero
   always_ff @(posedge sys_clk) begin
      if (anyRst) begin
         ackFlags_reg <= can_msg_status_pkg::ACK_RESET;
      end else begin
         ackFlags_reg <= ackFlags_next;
      end
   end

   // ----------------------------------------------------------------
   // Per-center control registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_reg [NUM_CENTERS];
   logic [NUM_CENTERS-1:0] irqBits;

   generate
      for (g = 0; g < NUM_CENTERS; g++) begin : gCenter
         localparam bit RX_ONLY = (g == NUM_CENTERS - 1);
         logic [7:0] c;
         logic [7:0] c_next;
         logic       isTx;
         logic       wr;
         logic       ready;
         logic       txEvt;
         logic       rxEvt;
         logic       remEvt;

         assign c      = ctrl_reg[g];
         assign isTx   = txDirection[g] && !RX_ONLY;
         assign wr     = wrStrobe && hitCenter[g];
         assign ready  = c[can_msg_status_pkg::SLOT_READY_BIT];
         // Engine events for a parked center are discarded
         assign txEvt  = engineEvt.txDone[g] && ready && !RX_ONLY;
         assign rxEvt  = engineEvt.rxStore[g] && ready && !isTx;
         assign remEvt = engineEvt.remoteReq[g] && ready;
         assign txOk[g] = txEvt;

         always_comb begin
            c_next = c;
            if (wr) begin
               c_next[7:4] = pwdata[7:4];
               if (!pwdata[can_msg_status_pkg::REMOTE_PEND_BIT]) begin
                  c_next[can_msg_status_pkg::REMOTE_PEND_BIT] = 1'b0;
               end
               if (pwdata[can_msg_status_pkg::HOST_TX_REQ_BIT]) begin
                  c_next[can_msg_status_pkg::HOST_TX_REQ_BIT] = 1'b1;
               end
               if (isTx) begin
                  c_next[can_msg_status_pkg::HOLD_OVR_BIT]   = pwdata[can_msg_status_pkg::HOLD_OVR_BIT];
                  c_next[can_msg_status_pkg::DATA_FRESH_BIT] = pwdata[can_msg_status_pkg::DATA_FRESH_BIT];
               end else if (!pwdata[can_msg_status_pkg::DATA_FRESH_BIT]) begin
                  c_next[can_msg_status_pkg::DATA_FRESH_BIT] = 1'b0;
                  c_next[can_msg_status_pkg::HOLD_OVR_BIT]   = 1'b0;
               end
            end
            // Hardware events after software so that the hardware event wins, set or clear
            if (txEvt) begin
               c_next[can_msg_status_pkg::HOST_TX_REQ_BIT] = 1'b0;
               if (isTx) begin
                  c_next[can_msg_status_pkg::REMOTE_PEND_BIT] = 1'b0;
               end
               if (c[can_msg_status_pkg::TX_IRQ_EN_BIT]) begin
                  c_next[can_msg_status_pkg::SLOT_IRQ_REQ_BIT] = 1'b1;
               end
            end
            if (rxEvt) begin
               if (c[can_msg_status_pkg::DATA_FRESH_BIT]) begin
                  c_next[can_msg_status_pkg::HOLD_OVR_BIT] = 1'b1;
               end
               c_next[can_msg_status_pkg::DATA_FRESH_BIT] = 1'b1;
               if (c[can_msg_status_pkg::RX_IRQ_EN_BIT]) begin
                  c_next[can_msg_status_pkg::SLOT_IRQ_REQ_BIT] = 1'b1;
               end
            end
            if (remEvt) begin
               c_next[can_msg_status_pkg::REMOTE_PEND_BIT] = 1'b1;
               if (isTx) begin
                  c_next[can_msg_status_pkg::HOST_TX_REQ_BIT] = 1'b1;
               end
            end
         end

         always_ff @(posedge sys_clk) begin
            if (anyRst) begin
               ctrl_reg[g] <= can_msg_status_pkg::CTRL_RESET;
            end else begin
               ctrl_reg[g] <= c_next;
            end
         end

         assign irqBits[g] = c[can_msg_status_pkg::SLOT_IRQ_REQ_BIT];

         // Engine permissions, registered below
         logic fresh;
         logic held;
         assign fresh = c[can_msg_status_pkg::DATA_FRESH_BIT];
         assign held  = c[can_msg_status_pkg::HOLD_OVR_BIT];

         // Per-center flops keep one writer per variable; the port is wired from them
         logic slotEn_reg;
         logic txAllow_reg;
         logic sendData_reg;
         logic sendRemote_reg;
         logic rxAllow_reg;

         always_ff @(posedge sys_clk) begin
            if (anyRst) begin
               slotEn_reg     <= 1'b0;
               txAllow_reg    <= 1'b0;
               sendData_reg   <= 1'b0;
               sendRemote_reg <= 1'b0;
               rxAllow_reg    <= 1'b0;
            end else begin
               slotEn_reg     <= c_next[can_msg_status_pkg::SLOT_READY_BIT];
               txAllow_reg    <= ready && isTx && fresh && !held;
               sendData_reg   <= ready && isTx && fresh && !held &&
                                 c[can_msg_status_pkg::HOST_TX_REQ_BIT];
               sendRemote_reg <= ready && !isTx && !RX_ONLY &&
                                 c[can_msg_status_pkg::HOST_TX_REQ_BIT];
               rxAllow_reg    <= ready && !isTx;
            end
         end

         assign engineCtl.slotEnabled[g] = slotEn_reg;
         assign engineCtl.txAllowed[g]   = txAllow_reg;
         assign engineCtl.sendData[g]    = sendData_reg;
         assign engineCtl.sendRemote[g]  = sendRemote_reg;
         assign engineCtl.rxAllowed[g]   = rxAllow_reg;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Interrupt request and soft reset status toward the processor
   // ----------------------------------------------------------------
   // Ack flags do not take part here
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         canIrq          <= 1'b0;
         softResetActive <= 1'b0;
      end else begin
         canIrq <= (|irqBits) && cfg_reg[can_msg_status_pkg::GLOBAL_IRQ_EN_BIT] &&
                   cfg_reg[can_msg_status_pkg::MODULE_MASK_BIT];
         softResetActive <= softRst;
      end
   end

   // ----------------------------------------------------------------
   // Read data and response
   // ----------------------------------------------------------------
   function automatic logic [31:0] readMux(input logic [11:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == can_msg_status_pkg::TX_ACK_FLAGS_ADDR) begin
         r = {17'h00000, ackFlags_reg};
      end
      if (a == can_msg_status_pkg::CTRL_CFG_ADDR) begin
         r = {29'h0000_0000, cfg_reg};
      end
      for (int i = 0; i < NUM_CENTERS; i++) begin
         if (hitCenter[i]) begin
            r = {24'h000000, ctrl_reg[i]};
         end
      end
      return r;
   endfunction

   logic mapped;
   assign mapped = hitAck || hitCfg || (|hitCenter);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access;
         pslverr <= access && !mapped;
         prdata  <= rdStrobe ? readMux(paddr) : 32'h0000_0000;
      end
   end

endmodule

// [test/can_node_model.sv]
// Behavioural model of the other CAN nodes feeding engine events
`timescale 1ns/1ps
module can_node_model (
   // Clock
   input  wire logic                            sys_clk,
   // Stimulus from the bench
   input  wire logic [14:0]                     txReq,
   input  wire logic [14:0]                     rxReq,
   input  wire logic [14:0]                     remReq,
   // Engine side of the block
   input  wire can_msg_status_pkg::engine_ctl_t engineCtl,
   output can_msg_status_pkg::engine_evt_t      engineEvt
);
   // Events only reach centers the block offers
   always_ff @(posedge sys_clk) begin
      engineEvt.txDone    <= txReq & (engineCtl.sendData | engineCtl.sendRemote);
      engineEvt.rxStore   <= rxReq & engineCtl.rxAllowed;
      engineEvt.remoteReq <= remReq & engineCtl.slotEnabled;
   end
endmodule

// [test/can_msg_status_checker.sv]
// Assertions on the ports of the message center status block
`timescale 1ns/1ps
module can_msg_status_checker #(
   parameter int NUM_CENTERS = 15
) (
   input wire logic                            sys_clk,
   input wire logic                            rst,
   input wire logic                            psel,
   input wire logic                            penable,
   input wire logic                            pwrite,
   input wire logic [11:0]                     paddr,
   input wire logic [31:0]                     pwdata,
   input wire logic [31:0]                     prdata,
   input wire logic                            pready,
   input wire logic                            pslverr,
   input wire can_msg_status_pkg::engine_evt_t engineEvt,
   input wire logic [NUM_CENTERS-1:0]          txDirection,
   input wire can_msg_status_pkg::engine_ctl_t engineCtl,
   input wire logic                            canIrq,
   input wire logic                            softResetActive
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence accessPh; psel && penable && !pready; endsequence
   sequence readDone; pready && !pwrite; endsequence
   handshake_a: assert property (accessPh |=> pready) else $error("pready late");
   pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   ack_rsvd_a: assert property (readDone and paddr == can_msg_status_pkg::TX_ACK_FLAGS_ADDR
      |-> prdata[31:15] == 17'h00000) else $error("ack bit 15 not zero");
   ctl_rsvd_a: assert property (readDone and paddr >= can_msg_status_pkg::MSG_CENTER_ONE_ADDR
      and paddr <= can_msg_status_pkg::MSG_CENTER_ONE_ADDR + 12'h038 |-> prdata[31:8] == 24'h000000)
      else $error("control high bits not zero");
   tx_gate_a: assert property ((engineCtl.txAllowed & ~engineCtl.slotEnabled) == 15'h0000)
      else $error("transmit offered for unready center");
   rx_gate_a: assert property ((engineCtl.rxAllowed & ~engineCtl.slotEnabled) == 15'h0000)
      else $error("receive offered for unready center");
   last_rx_only_a: assert property (!engineCtl.sendData[14] && !engineCtl.sendRemote[14])
      else $error("center 15 asked to send");
   data_dir_a: assert property ($stable(txDirection) [*2] |-> (engineCtl.sendData & ~txDirection) == 15'h0000)
      else $error("data frame from receive center");
   soft_clear_a: assert property (softResetActive [*3] |-> engineCtl == '0)
      else $error("engine controls live in soft reset");
endmodule
bind can_message_center_status can_msg_status_checker #(.NUM_CENTERS(NUM_CENTERS)) can_msg_status_checker_i (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .engineEvt(engineEvt),
   .txDirection(txDirection), .engineCtl(engineCtl), .canIrq(canIrq), .softResetActive(softResetActive));

// [test/can_message_center_status_tb_top.sv]
// Self-checking bench for the message center status block
`timescale 1ns/1ps
module can_message_center_status_tb_top;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, canIrq, softResetActive, lastErr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] txDirection, txReq, rxReq, remReq;
   can_msg_status_pkg::engine_evt_t engineEvt;
   can_msg_status_pkg::engine_ctl_t engineCtl;
   int miscompares = 0;
   int compares = 0;
   localparam logic [11:0] ACK = can_msg_status_pkg::TX_ACK_FLAGS_ADDR;
   localparam logic [11:0] C1 = can_msg_status_pkg::MSG_CENTER_ONE_ADDR;
   localparam logic [11:0] C2 = C1 + 12'h004;
   localparam logic [11:0] CFG = can_msg_status_pkg::CTRL_CFG_ADDR;
   can_message_center_status can_message_center_status_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .engineEvt(engineEvt), .txDirection(txDirection), .engineCtl(engineCtl),
      .canIrq(canIrq), .softResetActive(softResetActive));
   can_node_model can_node_model_i (.sys_clk(sys_clk), .txReq(txReq), .rxReq(rxReq), .remReq(remReq),
      .engineCtl(engineCtl), .engineEvt(engineEvt));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h00000000);
      chk(nm, e, rd);
   endtask
   // Kind 0 transmit done, 1 receive store, 2 remote request
   task automatic evt(input int kind, input logic [14:0] m);
      @(posedge sys_clk);
      if (kind == 0) txReq <= m; else if (kind == 1) rxReq <= m; else remReq <= m;
      @(posedge sys_clk);
      txReq <= '0; rxReq <= '0; remReq <= '0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic t_reset;
      rdChk("ack", ACK, 32'h00000000);
      rdChk("ctrl1", C1, 32'h00000000);
      rdChk("unmapped", 12'hFFC, 32'h00000000);
      chk("pslverr", 32'h00000001, {31'h0, lastErr});
   endtask
   task automatic t_tx;
      xfer(1'b1, C1, 32'hFFFFFFC5);
      rdChk("ctrl1 write", C1, 32'h000000C5);
      evt(0, 15'h0001);
      rdChk("ctrl1 done", C1, 32'h000000D1);
      xfer(1'b1, CFG, 32'h00000006);
      repeat (2) @(posedge sys_clk);
      chk("canIrq on", 32'h00000001, {31'h0, canIrq});
      rdChk("ack set", ACK, 32'h00000001);
      rdChk("ack clear", ACK, 32'h00000000);
      xfer(1'b1, C1, 32'h000000C1);
      repeat (2) @(posedge sys_clk);
      chk("canIrq off", 32'h00000000, {31'h0, canIrq});
   endtask
   task automatic t_remote;
      evt(2, 15'h0001);
      rdChk("ctrl1 remote", C1, 32'h000000CD);
      evt(0, 15'h0001);
      rdChk("ctrl1 answered", C1, 32'h000000D1);
   endtask
   task automatic t_rx;
      xfer(1'b1, C2, 32'h000000A0);
      evt(1, 15'h0002);
      rdChk("ctrl2 store", C2, 32'h000000B1);
      evt(1, 15'h0002);
      rdChk("ctrl2 overwrite", C2, 32'h000000B3);
      xfer(1'b1, C2, 32'h000000A1);
      rdChk("ctrl2 keep", C2, 32'h000000A3);
      xfer(1'b1, C2, 32'h000000A0);
      rdChk("ctrl2 clear", C2, 32'h000000A0);
      evt(2, 15'h0002);
      rdChk("ctrl2 remote", C2, 32'h000000A8);
      xfer(1'b1, C2, 32'h000000A0);
      rdChk("ctrl2 pend clr", C2, 32'h000000A0);
   endtask
   task automatic t_soft;
      xfer(1'b1, C1, 32'h000000C5);
      evt(0, 15'h0001);
      xfer(1'b1, CFG, 32'h00000001);
      repeat (2) @(posedge sys_clk);
      chk("softResetActive", 32'h00000001, {31'h0, softResetActive});
      rdChk("ack soft", ACK, 32'h00000000);
      rdChk("ctrl1 soft", C1, 32'h00000000);
      xfer(1'b1, CFG, 32'h00000000);
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      txDirection = 15'h0001; txReq = '0; rxReq = '0; remReq = '0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_tx();
      t_remote();
      t_rx();
      t_soft();
      print_verdict();
   end
   // Whole run is under two hundred cycles
   initial begin
      #100us;
      miscompares++;
      print_verdict();
   end
endmodule
